// file: awmrc_regs.vh
// Function
// [R1] Less-than low byte, read-write, resets zero
// [R2] Results compared as 10-bit unsigned values
// [R3] Inside window: greater-than < result < less-than
// [R4] Outside window: below lower or above upper
// [R5] Mode chosen only by limit register values
// [R6] Window flag lives in converter control register
// [R7] Left-justified results use same comparison values
// [R8] Input select bits 7:5 read-only, reset 0x80
// [R9] Five-bit code maps to pins, sensor, supply
// [R10] Software sets converter pins analog and skipped
// [R11] Software enables sensor before measuring it
// [R12] Sensor enable is reference control bit 2
// [R13] Temperature offset stored left-justified, read-only
// [R14] Reference select: 0 pin, 1 supply
// [R15] Regulator override forces regulated reference
// [R16] Bias on by peripheral demand or bit
// [R17] Gain select sets buffer 1x or 2x
// [R18] Gain bit 0 means 2x, 1 means 1x
// [R19] Buffer enable drives reference onto pin
// [R20] Software clears buffer enable when unused
// [R21] Software sets reference pin analog and skipped
// [R22] Compare once per conversion, flag sticky
// [R23] Limits and result formed high:low bytes
`ifndef AWMRC_REGS_VH
`define AWMRC_REGS_VH
// Register indices; byte address is four times the index
`define AWMRC_IDX_INSEL       8'hbb
`define AWMRC_IDX_GT_LOW      8'hc3
`define AWMRC_IDX_GT_HIGH     8'hc4
`define AWMRC_IDX_LT_LOW      8'hc5
`define AWMRC_IDX_LT_HIGH     8'hc6
`define AWMRC_IDX_REFCTL      8'hd1
`define AWMRC_IDX_CONVCTL     8'he8
`define AWMRC_IDX_RESULT_LOW  8'hbd
`define AWMRC_IDX_RESULT_HIGH 8'hbe
`define AWMRC_IDX_TOFF_LOW    8'hf0
`define AWMRC_IDX_TOFF_HIGH   8'hf1
// Reset values
`define AWMRC_RST_INSEL       8'h80
`define AWMRC_RST_GT          8'hff
`define AWMRC_RST_LT          8'h00
`define AWMRC_RST_REFCTL      8'h00
`define AWMRC_RST_CONVCTL     8'h00
// Field positions
`define AWMRC_INSEL_FIXED     3'h4
`define AWMRC_CONV_WINFLAG    3
`define AWMRC_CONV_JUSTIFY    2
`define AWMRC_REF_GAIN        7
`define AWMRC_REF_OVERRIDE    4
`define AWMRC_REF_SELECT      3
`define AWMRC_REF_TEMPEN      2
`define AWMRC_REF_BIASEN      1
`define AWMRC_REF_BUFEN       0
`define AWMRC_REFCTL_WMASK    8'h9f
// Input select codes
`define AWMRC_SEL_TEMP        5'h1e
`define AWMRC_SEL_SUPPLY      5'h1f
`define AWMRC_SEL_LAST_PIN    5'h14
// Reference source encoding
`define AWMRC_VSRC_PIN        2'h0
`define AWMRC_VSRC_SUPPLY     2'h1
`define AWMRC_VSRC_REGULATED  2'h2
`endif

// file: awmrc_window_cmp.v
`include "awmrc_regs.vh"
`default_nettype none
// Window comparator on 16-bit words
module awmrc_window_cmp (
    // Compared values
    input  wire [15:0] result_word,
    input  wire [15:0] gt_limit,
    input  wire [15:0] lt_limit,
    // Outcome
    output wire        hit
);
    // Mode follows limit order only
    wire inside_mode = (lt_limit > gt_limit);                     // [R5]
    wire above_gt    = (result_word > gt_limit);
    wire below_lt    = (result_word < lt_limit);
    // Inside: both; outside: either
    assign hit = inside_mode ? (above_gt & below_lt)              // [R3]
                             : (above_gt | below_lt);             // [R4]
endmodule // awmrc_window_cmp
`default_nettype wire

// file: awmrc_ctrl.v
// The APB register port was left to the implementer.
`include "awmrc_regs.vh"
`default_nettype none
module awmrc_ctrl (
    // Clock and reset
    input  wire        clock,
    input  wire        srst,
    // APB slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [9:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // Converter core
    input  wire        conv_done,
    input  wire [9:0]  conv_data,
    // Factory offset from program memory and peripheral bias demand
    input  wire [9:0]  temp_offset,
    input  wire        periph_bias_req,
    // Analog controls
    output reg  [4:0]  mux_select,
    output reg         mux_valid,
    output reg  [1:0]  vref_source,
    output reg         temp_sensor_on,
    output reg         bias_on,
    output reg         ref_gain_1x,
    output reg         ref_buffer_on,
    output reg         window_compare_flag
);
    // Registers
    reg  [7:0]  insel_ff;
    reg  [7:0]  gt_low_ff;
    reg  [7:0]  gt_high_ff;
    reg  [7:0]  lt_low_ff;
    reg  [7:0]  lt_high_ff;
    reg  [7:0]  refctl_ff;
    reg  [7:0]  convctl_ff;
    reg  [7:0]  res_low_ff;
    reg  [7:0]  res_high_ff;
    reg         eval_ff;
    reg         bias_req_s1_ff;
    reg         bias_req_s2_ff;
    reg         done_s1_ff;
    reg         done_s2_ff;
    reg         done_s3_ff;
    reg  [9:0]  data_s1_ff;
    reg  [9:0]  data_s2_ff;
    reg  [7:0]  nxt_rdata;
    wire [7:0]  word_addr = paddr[9:2];
    // Writes land at the edge that completes the access
    wire        wr_en = psel & penable & pwrite & pready;
    wire        rd_en = psel & penable & ~pwrite & ~pready;
    wire        done_pulse = done_s2_ff & ~done_s3_ff;
    wire [15:0] result_word = {res_high_ff, res_low_ff};          // [R23]
    wire [15:0] gt_word = {gt_high_ff, gt_low_ff};                // [R23]
    wire [15:0] lt_word = {lt_high_ff, lt_low_ff};                // [R23]
    wire        win_hit;
    wire        wr_conv = wr_en && (word_addr == `AWMRC_IDX_CONVCTL);
    wire        set_flag = eval_ff & win_hit;

    awmrc_window_cmp u_cmp (
        .result_word (result_word),
        .gt_limit    (gt_word),
        .lt_limit    (lt_word),
        .hit         (win_hit)
    );

    // Synchronise converter pins and peripheral bias request
    always @(posedge clock) begin
        if (srst) begin
            done_s1_ff     <= 1'b0;
            done_s2_ff     <= 1'b0;
            done_s3_ff     <= 1'b0;
            data_s1_ff     <= 10'h000;
            data_s2_ff     <= 10'h000;
            bias_req_s1_ff <= 1'b0;
            bias_req_s2_ff <= 1'b0;
        end else begin
            done_s1_ff     <= conv_done;
            done_s2_ff     <= done_s1_ff;
            done_s3_ff     <= done_s2_ff;
            data_s1_ff     <= conv_data;
            data_s2_ff     <= data_s1_ff;
            bias_req_s1_ff <= periph_bias_req;
            bias_req_s2_ff <= bias_req_s1_ff;
        end
    end

    // Latch result per conversion, justified per control bit
    always @(posedge clock) begin
        if (srst) begin
            res_low_ff  <= 8'h00;
            res_high_ff <= 8'h00;
            eval_ff     <= 1'b0;
        end else begin
            eval_ff <= done_pulse;                                // [R22]
            if (done_pulse) begin
                if (convctl_ff[`AWMRC_CONV_JUSTIFY]) begin        // [R7]
                    res_high_ff <= data_s2_ff[9:2];
                    res_low_ff  <= {data_s2_ff[1:0], 6'h00};
                end else begin                                    // [R2]
                    res_high_ff <= {6'h00, data_s2_ff[9:8]};
                    res_low_ff  <= data_s2_ff[7:0];
                end
            end
        end
    end

    // Register writes
    always @(posedge clock) begin
        if (srst) begin
            insel_ff   <= `AWMRC_RST_INSEL;                       // [R8]
            gt_low_ff  <= `AWMRC_RST_GT;
            gt_high_ff <= `AWMRC_RST_GT;
            lt_low_ff  <= `AWMRC_RST_LT;                          // [R1]
            lt_high_ff <= `AWMRC_RST_LT;
            refctl_ff  <= `AWMRC_RST_REFCTL;
            convctl_ff <= `AWMRC_RST_CONVCTL;
        end else begin
            if (wr_en) begin
                case (word_addr)
                    `AWMRC_IDX_INSEL:
                        insel_ff <= {`AWMRC_INSEL_FIXED,
                                     pwdata[4:0]};                // [R8]
                    `AWMRC_IDX_GT_LOW:  gt_low_ff  <= pwdata[7:0];
                    `AWMRC_IDX_GT_HIGH: gt_high_ff <= pwdata[7:0];
                    `AWMRC_IDX_LT_LOW:  lt_low_ff  <= pwdata[7:0]; // [R1]
                    `AWMRC_IDX_LT_HIGH: lt_high_ff <= pwdata[7:0];
                    `AWMRC_IDX_REFCTL:
                        refctl_ff <= pwdata[7:0] & `AWMRC_REFCTL_WMASK;
                    default: ;
                endcase
            end
            // Flag: set wins over software clear
            if (wr_conv) begin
                convctl_ff <= pwdata[7:0];
            end
            if (set_flag) begin
                convctl_ff[`AWMRC_CONV_WINFLAG] <= 1'b1;          // [R6] [R22]
            end
        end
    end

    // Read mux
    always @* begin
        case (word_addr)
            `AWMRC_IDX_INSEL:       nxt_rdata = insel_ff;
            `AWMRC_IDX_GT_LOW:      nxt_rdata = gt_low_ff;
            `AWMRC_IDX_GT_HIGH:     nxt_rdata = gt_high_ff;
            `AWMRC_IDX_LT_LOW:      nxt_rdata = lt_low_ff;
            `AWMRC_IDX_LT_HIGH:     nxt_rdata = lt_high_ff;
            `AWMRC_IDX_REFCTL:      nxt_rdata = refctl_ff;
            `AWMRC_IDX_CONVCTL:     nxt_rdata = convctl_ff;
            `AWMRC_IDX_RESULT_LOW:  nxt_rdata = res_low_ff;
            `AWMRC_IDX_RESULT_HIGH: nxt_rdata = res_high_ff;
            `AWMRC_IDX_TOFF_HIGH:   nxt_rdata = temp_offset[9:2];  // [R13]
            `AWMRC_IDX_TOFF_LOW:
                nxt_rdata = {temp_offset[1:0], 6'h00};            // [R13]
            default:                nxt_rdata = 8'h00;
        endcase
    end

    // APB answer: one wait state, error on misaligned address
    always @(posedge clock) begin
        if (srst) begin
            prdata  <= 32'h00000000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else if (psel & penable & ~pready) begin
            pready  <= 1'b1;
            prdata  <= rd_en ? {24'h000000, nxt_rdata} : 32'h00000000;
            pslverr <= (paddr[1:0] != 2'h0);
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // Analog control outputs
    always @(posedge clock) begin
        if (srst) begin
            mux_select          <= 5'h00;
            mux_valid           <= 1'b0;
            vref_source         <= `AWMRC_VSRC_PIN;
            temp_sensor_on      <= 1'b0;
            bias_on             <= 1'b0;
            ref_gain_1x         <= 1'b0;
            ref_buffer_on       <= 1'b0;
            window_compare_flag <= 1'b0;
        end else begin
            mux_select <= insel_ff[4:0];                          // [R9]
            mux_valid  <= (insel_ff[4:0] <= `AWMRC_SEL_LAST_PIN) ||
                          (insel_ff[4:0] == `AWMRC_SEL_TEMP) ||
                          (insel_ff[4:0] == `AWMRC_SEL_SUPPLY);   // [R9]
            if (refctl_ff[`AWMRC_REF_OVERRIDE])
                vref_source <= `AWMRC_VSRC_REGULATED;             // [R15]
            else if (refctl_ff[`AWMRC_REF_SELECT])
                vref_source <= `AWMRC_VSRC_SUPPLY;                // [R14]
            else
                vref_source <= `AWMRC_VSRC_PIN;                   // [R14]
            temp_sensor_on <= refctl_ff[`AWMRC_REF_TEMPEN];       // [R12]
            bias_on <= refctl_ff[`AWMRC_REF_BIASEN] |
                       bias_req_s2_ff;                            // [R16]
            ref_gain_1x <= refctl_ff[`AWMRC_REF_GAIN];            // [R17] [R18]
            ref_buffer_on <= refctl_ff[`AWMRC_REF_BUFEN];         // [R19]
            window_compare_flag <= convctl_ff[`AWMRC_CONV_WINFLAG];
        end
    end
endmodule // awmrc_ctrl
`default_nettype wire

// file: awmrc_ctrl_monitor.sv
`default_nettype none
module awmrc_ctrl_monitor (
    // Clock and reset
    input wire logic        clock,
    input wire logic        srst,
    // Register bus
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [9:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    // Analog side
    input wire logic        periph_bias_req,
    input wire logic        mux_valid,
    input wire logic        bias_on,
    input wire logic        window_compare_flag,
    input wire logic [4:0]  mux_select,
    input wire logic [1:0]  vref_source
);
    timeunit 1ns;
    timeprecision 1ns;
    // Control register write in flight
    wire logic wr_conv = psel && pwrite && paddr[9:2] == 8'he8;
    default clocking @(posedge clock); endclocking
    default disable iff (srst);
    sequence s_req; psel && penable && !pready; endsequence
    sequence s_ovr;
        s_req ##0 (pwrite && paddr[9:2] == 8'hd1 && pwdata[4]);
    endsequence
    chk_one_wait: assert property (s_req |=> pready ##1 !pready)
        else $error("bus answer late or not a pulse");
    chk_err_align: assert property (pslverr |-> pready && paddr[1:0] != 2'h0)
        else $error("error flag without misaligned access");
    chk_rd_upper: assert property (pready |-> prdata[31:8] == 24'h0)
        else $error("read data upper bits set");
    chk_mux_valid: assert property (
        !$past(srst) |->
        mux_valid == (mux_select < 5'h15 || mux_select > 5'h1d))
        else $error("select valid flag wrong");
    chk_ref_ovr: assert property (
        s_ovr |-> ##[1:3] vref_source == 2'h2)
        else $error("override did not pick regulated reference");
    chk_bias_dem: assert property (
        periph_bias_req [*5] |-> bias_on)
        else $error("bias off under peripheral demand");
    chk_flag_sticky: assert property (
        $fell(window_compare_flag) |->
        $past(wr_conv) || $past(wr_conv, 2) || $past(wr_conv, 3))
        else $error("window flag dropped without a clear");
    chk_reset_out: assert property ($fell(srst) |->
        !pready && !window_compare_flag && vref_source == 2'h0)
        else $error("outputs not idle after reset");
endmodule // awmrc_ctrl_monitor
bind awmrc_ctrl awmrc_ctrl_monitor i_mon (.clock, .srst, .psel, .penable,
    .pwrite, .pready, .pslverr, .paddr, .pwdata, .prdata, .periph_bias_req,
    .mux_valid, .bias_on, .window_compare_flag, .mux_select, .vref_source);
`default_nettype wire

// file: awmrc_core_model.sv
`default_nettype none
module awmrc_core_model #(
    parameter logic [9:0] OFFSET = 10'h2c5
) (
    // Clock
    input  wire logic       clock,
    // Converter results
    output var  logic       conv_done,
    output var  logic [9:0] conv_data,
    // Factory offset and bias demand
    output var  logic [9:0] temp_offset,
    output var  logic       periph_bias_req
);
    timeunit 1ns;
    timeprecision 1ns;
    // Idle levels and the fixed offset word
    initial {conv_done, periph_bias_req, conv_data, temp_offset} =
        {2'b00, 10'h2aa, OFFSET};
    // Some peripheral asks for the bias generator
    task automatic demand(input logic on);
        periph_bias_req <= on;
    endtask
    // One conversion; data goes stale once done drops
    task automatic convert(input logic [9:0] d, input int lag);
        conv_data <= d;
        repeat (lag) @(posedge clock);
        conv_done <= 1'b1;
        repeat (4) @(posedge clock);
        conv_done <= 1'b0;
        conv_data <= ~d;
        repeat (4) @(posedge clock);
    endtask
endmodule // awmrc_core_model
`default_nettype wire

// file: awmrc_ctrl_bench.sv
`default_nettype none
module awmrc_ctrl_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clock, srst, psel, penable, pwrite, pready, pslverr, err;
    logic        conv_done, periph_bias_req, mux_valid, bias_on, ref_gain_1x;
    logic        temp_sensor_on, ref_buffer_on, window_compare_flag;
    logic [9:0]  paddr, conv_data, temp_offset;
    logic [31:0] pwdata, prdata, rd;
    logic [4:0]  mux_select;
    logic [1:0]  vref_source;
    int          miscompares = 0, check_count = 0;
    wire logic [5:0] ref_outs = {ref_gain_1x, vref_source, temp_sensor_on,
        bias_on, ref_buffer_on};
    awmrc_ctrl i_dut (.clock, .srst, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .conv_done, .conv_data,
        .temp_offset, .periph_bias_req, .mux_select, .mux_valid, .vref_source,
        .temp_sensor_on, .bias_on, .ref_gain_1x, .ref_buffer_on,
        .window_compare_flag);
    awmrc_core_model i_core (.clock, .conv_done, .periph_bias_req,
        .conv_data, .temp_offset);
    // System clock
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    task automatic cmp(input string n, input logic [31:0] e, g);
        check_count++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] %s exp %h got %h", n, e, g);
        end
    endtask
    // One APB transfer, held until pready is seen
    task automatic bus(input logic w, input logic [7:0] i, input logic [7:0] d,
                       input logic [1:0] lo = 2'b00);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, i, lo, 24'h0, d};
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        {rd, err} = {prdata, pslverr};
        cmp("pready", 1, pready);
        {psel, penable} <= 2'b00;
        @(posedge clock);
    endtask
    task automatic rdc(input string n, input logic [7:0] i, logic [31:0] e);
        bus(1'b0, i, 8'h00);
        cmp(n, e, rd);
        cmp("slverr", 0, err);
    endtask
    task automatic conclude;
        if (miscompares == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic t_regs;
        logic [7:0] v[3] = '{8'hff, 8'h08, 8'h00};
        logic [5:0] e[3] = '{6'h37, 6'h08, 6'h00};
        rdc("insel", 8'hbb, 32'h80);
        rdc("lt_low", 8'hc5, 32'h00);
        rdc("unmapped", 8'h10, 32'h00);
        bus(1'b1, 8'hc5, 8'ha5);
        rdc("lt_low", 8'hc5, 32'ha5);
        foreach (v[k]) begin
            bus(1'b1, 8'hd1, v[k]);
            rdc("refctl", 8'hd1, {24'h0, v[k] & 8'h9f});
            cmp("ref_outs", e[k], ref_outs);
        end
        i_core.demand(1'b1);
        repeat (6) @(posedge clock);
        cmp("bias_on", 1, bias_on);
        i_core.demand(1'b0);
        rdc("toff_high", 8'hf1, 32'hb1);
        rdc("toff_low", 8'hf0, 32'h40);
        bus(1'b0, 8'hc5, 8'h00, 2'b01);
        cmp("slverr", 1, err);
    endtask
    task automatic t_mux;
        for (int k = 0; k < 32; k++) begin
            bus(1'b1, 8'hbb, 8'he0 | k[7:0]);
            @(posedge clock);
            cmp("mux", {k < 21 || k > 29, k[4:0]},
                {mux_valid, mux_select});
        end
        rdc("insel", 8'hbb, 32'h9f);
    endtask
    task automatic lim(input logic [31:0] v);
        for (int k = 0; k < 4; k++) bus(1'b1, 8'hc3 + k[7:0], v[8*k +: 8]);
    endtask
    task automatic cv(input logic [9:0] d, input logic e, input logic [7:0] c);
        i_core.convert(d, d[0] ? 1 : 5);
        rdc("convctl", 8'he8, {e, c[2:0]});
        bus(1'b1, 8'he8, c);
    endtask
    task automatic t_window;
        lim({16'h0080, 16'h0040});
        cv(10'h040, 1'b0, 8'h00);
        cv(10'h041, 1'b1, 8'h00);
        cv(10'h080, 1'b0, 8'h00);
        i_core.convert(10'h041, 2);
        i_core.convert(10'h010, 2);
        cmp("flag_pin", 1, window_compare_flag);
        rdc("res_low", 8'hbd, 32'h10);
        bus(1'b1, 8'he8, 8'h00);
        lim({16'h0040, 16'h0080});
        cv(10'h03f, 1'b1, 8'h00);
        cv(10'h040, 1'b0, 8'h00);
        cv(10'h081, 1'b1, 8'h00);
        bus(1'b1, 8'he8, 8'h04);
        lim({16'h00c0, 16'h0040});
        cv(10'h002, 1'b1, 8'h04);
        cv(10'h001, 1'b0, 8'h04);
        rdc("res_low", 8'hbd, 32'h40);
    endtask
    // Reset in mid-run brings registers and outputs back
    task automatic t_reset;
        bus(1'b1, 8'hd1, 8'h0f);
        srst <= 1'b1;
        repeat (2) @(posedge clock);
        srst <= 1'b0;
        @(posedge clock);
        cmp("ref_outs", 0, ref_outs);
        rdc("lt_low", 8'hc5, 32'h00);
        rdc("insel", 8'hbb, 32'h80);
        rdc("refctl", 8'hd1, 32'h00);
    endtask
    // Reset, then the scenarios
    initial begin
        {srst, psel, penable, pwrite, paddr, pwdata} <= {1'b1, 45'h0};
        repeat (6) @(posedge clock);
        srst <= 1'b0;
        @(posedge clock);
        t_regs();
        t_mux();
        t_window();
        t_reset();
        conclude();
    end
    // Watchdog against a hang
    initial begin
        repeat (5000) @(posedge clock);
        miscompares++;
        conclude();
    end
endmodule // awmrc_ctrl_bench
`default_nettype wire
